// *** shared/aux_bus_pkg.sv ***
/*
 * Constants and carrier types for the auxiliary peripheral bus master.
 * Assumes one 125 MHz clock and host requests that are synchronous to it.
 */
// Overview of operation
// - Bus master with 16-bit two-way data and 6-bit address output.
// - Host address bits 7 to 2 drive the six auxiliary address lines.
// - Only data bits 15 to 0 move; byte enables must be 1100b.
// - Fixed default strobe timing, stretched while the peripheral is not ready.
// - Data, address, select and strobes share host-port pins; interrupt, ready, reset dedicated.
// - Chip select stays asserted throughout each access, deasserted otherwise.
// - Active-low read strobe; peripheral presents data by its rising edge.
// - Active-low write strobe; write data valid at its rising edge.
// - Active-low auxiliary reset output follows the global reset.
// - Write: select with address and data, pulse write strobe, then deselect.
// - Write strobe ends only after ready is sampled asserted.
// - Read: float data, hold read strobe until ready, then release and capture.
// - When idle the address and data lines are driven to stable values.
package aux_bus_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int SETUP_NS = 16;
	localparam int STROBE_NS = 40;
	localparam int HOLD_NS = 16;
	// Least times, so round up to whole cycles
	localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ************************************************************
	// Field positions and values
	// ************************************************************
	localparam int HOST_ADDR_LSB = 2;
	localparam int HOST_ADDR_MSB = 7;
	localparam logic [3:0] VALID_BE = 4'hc;
	localparam logic [5:0] ADDR_RST = 6'h00;
	localparam logic [15:0] DATA_RST = 16'h0000;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_STROBE = 4'h4,
		ST_HOLD = 4'h8
	} aux_state_t;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic write;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} aux_req_t;

	typedef struct packed {
		logic valid;
		logic error;
		logic [31:0] rdata;
	} aux_resp_t;

	// Shared pin group: host-port function or auxiliary function
	typedef struct packed {
		logic [15:0] data;
		logic data_oe;
		logic [5:0] addr;
		logic strobe;
		logic io5;
		logic io4;
	} shared_pins_t;

endpackage

// *** verification/aux_periph_model.sv ***
/*
 * Behavioural peripheral on the auxiliary bus: 64 words of 16 bits.
 * Assumes the bench resolves the data wire and feeds its level in.
 */
module aux_periph_model #(
	parameter int REC = 2
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire aux_bus_pkg::shared_pins_t pins_i,
	input wire logic [15:0] level_i,
	input wire logic [3:0] wait_i,
	output logic ready_o,
	output logic drive_o,
	output logic [15:0] data_o
);
	// ************************************************************
	// Storage and handshake
	// ************************************************************
	logic [15:0] mem_r [64];
	logic [3:0] cnt_r;
	logic [3:0] rec_r;
	logic strb_d_r;
	logic wr_d_r;
	logic strb_n;
	assign strb_n = pins_i.io5 & pins_i.io4;
	// Slow until wait_i cycles of strobe, then busy while recovering
	assign ready_o = (cnt_r >= wait_i) && (rec_r == 4'h0);
	// Data stays valid all through the low strobe, so by its rising edge
	assign drive_o = !pins_i.strobe && !pins_i.io5;
	assign data_o = mem_r[pins_i.addr];
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 4'h0;
			rec_r <= 4'h0;
			strb_d_r <= 1'b1;
			wr_d_r <= 1'b1;
		end else begin
			cnt_r <= strb_n ? 4'h0 : cnt_r + 4'h1;
			strb_d_r <= strb_n;
			wr_d_r <= pins_i.io4;
			if (strb_n && !strb_d_r) begin
				rec_r <= 4'(REC);
			end else if (rec_r != 4'h0) begin
				rec_r <= rec_r - 4'h1;
			end
		end
	end
	// Only sixteen bits are kept; latched at the write strobe's rise, never a read's
	always_ff @(posedge ref_clk_i) begin
		if (!pins_i.strobe && pins_i.io4 && !wr_d_r && pins_i.io5) begin
			mem_r[pins_i.addr] <= level_i;
		end
	end
endmodule

// *** verification/tb_top.sv ***
/*
 * Self-checking bench for the auxiliary bus master with a peripheral model.
 * Assumes the latencies and idle levels that the master's host contract gives.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Wiring
	// ************************************************************
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req_valid_i = 1'b0;
	aux_bus_pkg::aux_req_t req_i = '0;
	logic aux_mode_i = 1'b1;
	aux_bus_pkg::shared_pins_t host_port_i = '0;
	logic aux_interrupt_i = 1'b0;
	logic [3:0] wait_st = 4'h0;
	logic req_ready_o, aux_interrupt_o, aux_reset_n_o, mdrive, rdy;
	logic cs_n, rd_n, wr_n;
	aux_bus_pkg::aux_resp_t resp_o;
	aux_bus_pkg::shared_pins_t pins_o;
	logic [15:0] level, last_r, mdata;
	int mismatches = 0;
	int n_tests = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	// Undriven wire shows the inverse of its last level, never a kind zero
	assign level = pins_o.data_oe ? pins_o.data : (mdrive ? mdata : ~last_r);
	always @(posedge ref_clk_i) last_r <= level;
	aux_bus_master dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.resp_o(resp_o), .aux_mode_i(aux_mode_i), .host_port_i(host_port_i),
		.pins_o(pins_o), .pin_data_i(level), .aux_ready_i(rdy),
		.aux_interrupt_i(aux_interrupt_i), .aux_interrupt_o(aux_interrupt_o),
		.aux_reset_n_o(aux_reset_n_o), .aux_chip_select_n_o(cs_n),
		.aux_read_strobe_n_o(rd_n), .aux_write_strobe_n_o(wr_n));
	aux_periph_model periph (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pins_i(pins_o),
		.level_i(level), .wait_i(wait_st), .ready_o(rdy), .drive_o(mdrive), .data_o(mdata));
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (mismatches == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic access(input logic wr, input logic [31:0] addr, input logic [3:0] be,
			input logic [31:0] wd, input int lat, input logic err, input logic [15:0] rd);
		int n;
		int low;
		n = 0;
		low = 0;
		req_i = '{write: wr, addr: addr, be: be, wdata: wd};
		req_valid_i = 1'b1;
		do begin
			@(negedge ref_clk_i);
			if (n == 0) req_valid_i = 1'b0;
			n++;
			if (resp_o.valid !== 1'b1) begin
				low += ((wr ? wr_n : rd_n) === 1'b0) ? 1 : 0;
				check("select", 32'(cs_n), 32'h0);
				check("address", 32'(pins_o.addr), 32'(addr[7:2]));
				check("other strobe", 32'(wr ? rd_n : wr_n), 32'h1);
				check("drive", 32'(pins_o.data_oe), 32'(wr));
				check("busy", 32'(req_ready_o), 32'h0);
				if (wr && wr_n === 1'b0) check("wdata", 32'(pins_o.data), 32'(wd[15:0]));
			end
		end while (resp_o.valid !== 1'b1 && n < 40);
		check("latency", 32'(n), 32'(lat));
		check("strobe len", 32'(low), err ? 32'h0 : 32'(lat - 5));
		check("error", 32'(resp_o.error), 32'(err));
		check("select end", 32'(cs_n), 32'h1);
		if (!wr) check("rdata", resp_o.rdata, {16'h0000, rd});
		// A one-cycle answer gives no edge between release and the next request
		if (n == 1) @(negedge ref_clk_i);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic chk_reset();
		check("reset strobes", {29'h0, cs_n, rd_n, wr_n}, 32'h7);
		check("reset ready", 32'(req_ready_o), 32'h1);
		check("aux reset", 32'(aux_reset_n_o), 32'h0);
	endtask
	task automatic chk_access();
		access(1'b1, 32'h000ff0b0, 4'hc, 32'h1234bbaa, 10, 1'b0, 16'h0);
		access(1'b1, 32'h000000fc, 4'hc, 32'hffff5a5a, 10, 1'b0, 16'h0);
		check("idle data", 32'(pins_o.data), 32'h5a5a);
		check("idle drive", 32'(pins_o.data_oe), 32'h1);
		access(1'b0, 32'h000ff0b0, 4'hc, 32'h0, 10, 1'b0, 16'hbbaa);
		access(1'b0, 32'h000000fc, 4'hc, 32'h0, 10, 1'b0, 16'h5a5a);
	endtask
	task automatic chk_slow();
		wait_st = 4'h6;
		access(1'b1, 32'h00000040, 4'hc, 32'h0000c3c3, 12, 1'b0, 16'h0);
		access(1'b0, 32'h00000040, 4'hc, 32'h0, 12, 1'b0, 16'hc3c3);
		wait_st = 4'h0;
	endtask
	task automatic chk_refuse();
		logic [3:0] bad [4] = '{4'h0, 4'h3, 4'hf, 4'he};
		foreach (bad[i]) begin
			access(1'b1, 32'h00000040, bad[i], 32'h0000ffff, 1, 1'b1, 16'h0);
			access(1'b0, 32'h00000040, bad[i], 32'h0, 1, 1'b1, 16'h0000);
		end
		access(1'b0, 32'h00000040, 4'hc, 32'h0, 10, 1'b0, 16'hc3c3);
	endtask
	task automatic chk_pins();
		aux_interrupt_i = 1'b1;
		@(negedge ref_clk_i);
		check("irq high", 32'(aux_interrupt_o), 32'h1);
		aux_interrupt_i = 1'b0;
		aux_mode_i = 1'b0;
		host_port_i = '{data: 16'hc3a5, data_oe: 1'b1, addr: 6'h15, strobe: 1'b0,
			io5: 1'b1, io4: 1'b0};
		@(negedge ref_clk_i);
		check("irq low", 32'(aux_interrupt_o), 32'h0);
		check("host pins", 32'(pins_o), 32'(host_port_i));
		aux_mode_i = 1'b1;
		rst_n_i = 1'b0;
		@(negedge ref_clk_i);
		check("aux reset mid", 32'(aux_reset_n_o), 32'h0);
		check("idle select", 32'(pins_o.strobe), 32'h1);
		rst_n_i = 1'b1;
		@(negedge ref_clk_i);
		check("aux reset off", 32'(aux_reset_n_o), 32'h1);
		access(1'b0, 32'h00000040, 4'hc, 32'h0, 10, 1'b0, 16'hc3c3);
	endtask
	// ************************************************************
	// Sequence and watchdog
	// ************************************************************
	initial begin
		repeat (12) @(negedge ref_clk_i);
		chk_reset();
		rst_n_i = 1'b1;
		@(negedge ref_clk_i);
		chk_access();
		chk_slow();
		chk_refuse();
		chk_pins();
		close_out();
	end
	initial begin
		#24000;
		mismatches++;
		close_out();
	end
endmodule

// *** verilog/aux_bus_master.sv ***
/*
 * Auxiliary peripheral bus master: turns single-doubleword host requests
 * into strobed 16-bit reads and writes on pins shared with the host port.
 * Assumes the host holds a request until req_ready_o and all inputs are
 * synchronous to ref_clk_i.
 */
module aux_bus_master (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Host request side
	input wire logic req_valid_i,
	input wire aux_bus_pkg::aux_req_t req_i,
	output logic req_ready_o,
	output aux_bus_pkg::aux_resp_t resp_o,
	// Host-port function of the shared pins
	input wire logic aux_mode_i,
	input wire aux_bus_pkg::shared_pins_t host_port_i,
	// Shared pins
	output aux_bus_pkg::shared_pins_t pins_o,
	input wire logic [15:0] pin_data_i,
	// Dedicated auxiliary pins
	input wire logic aux_ready_i,
	input wire logic aux_interrupt_i,
	output logic aux_interrupt_o,
	output logic aux_reset_n_o,
	// Observed auxiliary levels
	output logic aux_chip_select_n_o,
	output logic aux_read_strobe_n_o,
	output logic aux_write_strobe_n_o
);

	// ************************************************************
	// State
	// ************************************************************
	aux_bus_pkg::aux_state_t state_r;
	aux_bus_pkg::aux_state_t state_nxt;
	logic write_r;
	logic cs_n_r;
	logic rd_n_r;
	logic wr_n_r;
	logic data_oe_r;
	logic [5:0] addr_r;
	logic [15:0] wdata_r;
	aux_bus_pkg::aux_resp_t resp_r;
	logic accept;
	logic bad_be;
	logic timer_load;
	logic [3:0] timer_count;
	logic timer_done;
	logic strobe_end;

	assign accept = (state_r == aux_bus_pkg::ST_IDLE) && req_valid_i;
	assign bad_be = req_i.be != aux_bus_pkg::VALID_BE;
	// Ready is only looked at once the least strobe width has passed
	assign strobe_end = (state_r == aux_bus_pkg::ST_STROBE) && timer_done
		&& aux_ready_i;

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		state_nxt = state_r;
		timer_load = 1'b0;
		timer_count = aux_bus_pkg::SETUP_CYC - 4'h1;
		case (state_r)
			aux_bus_pkg::ST_IDLE: begin
				if (accept && !bad_be) begin
					state_nxt = aux_bus_pkg::ST_SETUP;
					timer_load = 1'b1;
				end
			end
			aux_bus_pkg::ST_SETUP: begin
				if (timer_done) begin
					state_nxt = aux_bus_pkg::ST_STROBE;
					timer_load = 1'b1;
					timer_count = aux_bus_pkg::STROBE_CYC - 4'h1;
				end
			end
			aux_bus_pkg::ST_STROBE: begin
				if (strobe_end) begin
					state_nxt = aux_bus_pkg::ST_HOLD;
					timer_load = 1'b1;
					timer_count = aux_bus_pkg::HOLD_CYC - 4'h1;
				end
			end
			aux_bus_pkg::ST_HOLD: begin
				if (timer_done) begin
					state_nxt = aux_bus_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = aux_bus_pkg::ST_IDLE;
			end
		endcase
	end

	// One access at a time: new requests wait for idle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= aux_bus_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	aux_phase_timer #(
		.W(4)
	) phase_timer (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(timer_load),
		.count_i(timer_count),
		.done_o(timer_done)
	);

	// ************************************************************
	// Bus signals
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_n_r <= 1'b1;
		end else if (accept && !bad_be) begin
			cs_n_r <= 1'b0;
		end else if (state_r == aux_bus_pkg::ST_HOLD && timer_done) begin
			cs_n_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
		end else if (state_r == aux_bus_pkg::ST_SETUP && timer_done) begin
			rd_n_r <= write_r;
			wr_n_r <= !write_r;
		end else if (strobe_end) begin
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
		end
	end

	// Address and write data only change at accept, so they stay stable idle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			write_r <= 1'b0;
			addr_r <= aux_bus_pkg::ADDR_RST;
			wdata_r <= aux_bus_pkg::DATA_RST;
		end else if (accept && !bad_be) begin
			write_r <= req_i.write;
			addr_r <= req_i.addr[aux_bus_pkg::HOST_ADDR_MSB:aux_bus_pkg::HOST_ADDR_LSB];
			wdata_r <= req_i.wdata[15:0];
		end
	end

	// Data lines float only during a read; driven otherwise, also when idle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_oe_r <= 1'b1;
		end else if (accept && !bad_be) begin
			data_oe_r <= req_i.write;
		end else if (state_r == aux_bus_pkg::ST_HOLD && timer_done) begin
			data_oe_r <= 1'b1;
		end
	end

	// ************************************************************
	// Host answer
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resp_r <= '0;
		end else begin
			resp_r.valid <= (accept && bad_be)
				|| (state_r == aux_bus_pkg::ST_HOLD && timer_done);
			if (accept && bad_be) begin
				resp_r.error <= 1'b1;
				resp_r.rdata <= '0;
			end else if (strobe_end) begin
				resp_r.error <= 1'b0;
				// Captured as the read strobe rises; upper half reads as zero
				resp_r.rdata <= write_r ? 32'h00000000 : {16'h0000, pin_data_i};
			end
		end
	end

	assign resp_o = resp_r;
	assign req_ready_o = (state_r == aux_bus_pkg::ST_IDLE);

	// ************************************************************
	// Pin sharing and dedicated pins
	// ************************************************************
	// The host-port owner must not claim the pins while an access runs
	always_comb begin
		if (aux_mode_i) begin
			pins_o.data = wdata_r;
			pins_o.data_oe = data_oe_r;
			pins_o.addr = addr_r;
			pins_o.strobe = cs_n_r;
			pins_o.io5 = rd_n_r;
			pins_o.io4 = wr_n_r;
		end else begin
			pins_o = host_port_i;
		end
	end

	assign aux_chip_select_n_o = cs_n_r;
	assign aux_read_strobe_n_o = rd_n_r;
	assign aux_write_strobe_n_o = wr_n_r;
	assign aux_reset_n_o = rst_n_i;
	assign aux_interrupt_o = aux_interrupt_i;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence select_setup_s;
		(rd_n_r && wr_n_r && !cs_n_r) [*2];
	endsequence

	sequence strobe_hold_s;
		(!cs_n_r && rd_n_r && wr_n_r) [*2] ##1 cs_n_r;
	endsequence

	select_follows_state_a: assert property (cs_n_r == (state_r == aux_bus_pkg::ST_IDLE))
		else $error("chip select does not match access state");

	strobes_exclusive_a: assert property (!(!rd_n_r && !wr_n_r) && (!cs_n_r || (rd_n_r && wr_n_r)))
		else $error("strobes active together or outside select");

	setup_order_a: assert property ($fell(cs_n_r) |-> select_setup_s ##1 (!rd_n_r || !wr_n_r))
		else $error("strobe not asserted after two setup cycles");

	hold_order_a: assert property ($rose(rd_n_r) || $rose(wr_n_r) |-> strobe_hold_s)
		else $error("select not released two cycles after strobe");

	strobe_width_a: assert property ($fell(wr_n_r) || $fell(rd_n_r) |-> (!rd_n_r || !wr_n_r) [*5])
		else $error("strobe shorter than default width");

	ready_stretch_a: assert property ((!rd_n_r || !wr_n_r) && !aux_ready_i |=> (!rd_n_r || !wr_n_r))
		else $error("strobe ended without ready");

	read_float_a: assert property (!rd_n_r |-> !pins_o.data_oe || !aux_mode_i)
		else $error("data driven during read strobe");

	write_data_a: assert property ($rose(wr_n_r) |-> $stable(wdata_r) && $past(data_oe_r))
		else $error("write data not held at strobe release");

	address_map_a: assert property (accept && !bad_be |=>
		addr_r == 6'($past(req_i.addr) >> aux_bus_pkg::HOST_ADDR_LSB))
		else $error("address lines not host bits 7 to 2");

	bad_enable_a: assert property (accept && bad_be |=> resp_r.valid && resp_r.error && cs_n_r)
		else $error("invalid byte enables not refused");

	read_capture_a: assert property ($rose(rd_n_r) |-> resp_r.rdata == {16'h0000, $past(pin_data_i)})
		else $error("read data not captured at strobe release");

endmodule

// *** verilog/aux_phase_timer.sv ***
/*
 * Down counter that times one phase of an auxiliary access.
 * Assumes load is given on the edge that enters the phase.
 */
module aux_phase_timer #(
	parameter int W = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic [W-1:0] count_i,
	output logic done_o
);

	logic [W-1:0] cnt_r;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else if (load_i) begin
			cnt_r <= count_i;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end

	assign done_o = (cnt_r == '0);

endmodule
